// ==== dv/host_serial_port_config_monitor.sv ====
// Purpose: port-level checks of the host serial port
// Assumes: one clock, reset active low
// Notes:   bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_config_monitor (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        PTT_CLOSED,
	input wire logic        MORSE_SPECIAL,
	input wire logic        TXD_OUT,
	input wire logic [4:0]  LED_RUN
);
	// ------
	// helpers
	// ------
	logic [4:0] led_q;
	wire        acc   = HSEL && HREADY && HTRANS[1];
	wire        tx_wr = acc && HWRITE && (HADDR[7:2] == 6'h00);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// last led pattern, to judge each step
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			led_q <= 5'h00;
		else
			led_q <= LED_RUN;
	end
	// ------
	// checks
	// ------
	chk_resp_okay: assert property (HRESP == 1'b0)
		else $error("error response");
	chk_plain_no_wait: assert property (acc && !tx_wr |=> HREADYOUT)
		else $error("wait on plain access");
	chk_push_wait: assert property (tx_wr |=> !HREADYOUT)
		else $error("push without wait");
	chk_rdata_hold: assert property (!(acc && !HWRITE) |=> $stable(HRDATA))
		else $error("read data moved");
	chk_reset_mark: assert property ($rose(RST_N) |-> TXD_OUT [*2])
		else $error("line not at mark after reset");
	chk_bit_width: assert property (!PTT_CLOSED && $changed(TXD_OUT) |=> $stable(TXD_OUT) [*7])
		else $error("line bit too short");
	chk_ptt_quiet: assert property (PTT_CLOSED [*5] |-> $stable(TXD_OUT))
		else $error("line moved with push-to-talk closed");
	chk_led_onehot: assert property ($onehot0(LED_RUN))
		else $error("led pattern not one-hot");
	chk_led_start: assert property (led_q == 5'h00 && LED_RUN != 5'h00 |-> LED_RUN == 5'h01)
		else $error("led run bad start");
	chk_led_rotate: assert property (led_q != 5'h00 && LED_RUN != led_q && LED_RUN != 5'h00
		|-> LED_RUN == {led_q[3:0], led_q[4]})
		else $error("led run bad step");
	// main scenarios reached
	cov_stall: cover property (!HREADYOUT ##1 !HREADYOUT);
	cov_morse: cover property (MORSE_SPECIAL);
	cov_led: cover property (LED_RUN == 5'h02);
endmodule
`default_nettype wire

// ==== dv/host_serial_port_config_tb_top.sv ====
// Purpose: self-checking bench of the host serial port
// Assumes: terminal model on the line, one bus master
// Notes:   timing shortened through CLK_HZ
`timescale 1ns/1ps
`default_nettype none
`include "host_serial_port_config_defs.vh"
module host_serial_port_config_tb_top;
	// ------
	// set-up
	// ------
	localparam int CLK = 38400;
	localparam int B3  = 16 * (CLK * 100 / (16 * 30000));
	localparam int B1  = 16 * (CLK * 100 / (16 * 10000));
	localparam int B24 = 16 * (CLK * 100 / (16 * 240000));
	logic        CLOCK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic        PTT_CLOSED = 1'b0, MORSE_SPECIAL = 1'b0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, r;
	logic [1:0]  HTRANS = 2'h0;
	logic [7:0]  SWITCHES = 8'h13, c;
	logic        HREADYOUT, HRESP, TXD_OUT, RXD_IN;
	logic [4:0]  LED_RUN;
	wire  logic  HREADY;
	int          n_mismatch = 0, n_compared = 0, cyc = 0, n;
	assign HREADY = HREADYOUT;
	always #5 CLOCK = ~CLOCK;
	host_serial_port_config #(.CLK_HZ(CLK)) u_host_serial_port_config (.CLOCK(CLOCK), .RST_N(RST_N),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SWITCHES(SWITCHES),
		.RXD_IN(RXD_IN), .PTT_CLOSED(PTT_CLOSED), .MORSE_SPECIAL(MORSE_SPECIAL), .TXD_OUT(TXD_OUT),
		.LED_RUN(LED_RUN));
	host_terminal_model u_host_terminal_model (.clk(CLOCK), .line_in(TXD_OUT), .line_out(RXD_IN));
	// ------
	// shared tasks
	// ------
	// single word transfer, waits for each phase to be answered
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge CLOCK);
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'h2;
		do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
		q = HRDATA;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// new switches; the wait keeps a start bit clear of the idle flip
	task automatic cfg(input logic [7:0] s);
		@(posedge CLOCK);
		SWITCHES <= s;
		bus(1'b1, `REG_CTRL, 32'h2, r);
		repeat (40) @(posedge CLOCK);
	endtask
	task automatic wait_led(input logic [4:0] from);
		n = 0;
		while (LED_RUN === from && n < 1000) begin
			@(posedge CLOCK);
			n++;
		end
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset();
		chk(TXD_OUT, 1'b1);
		chk(LED_RUN, 5'h00);
		bus(1'b0, `REG_STATUS, 32'h0, r);
		chk(r, 32'h13);
		bus(1'b0, 32'h10, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h1, r);
		bus(1'b0, `REG_CTRL, 32'h0, r);
		chk(r, 32'h1);
		bus(1'b1, `REG_CTRL, 32'h0, r);
	endtask
	// six pushes overrun four slots and a shifter, so the bus must stall
	task automatic t_fifo();
		fork
			for (int i = 0; i < 6; i++) bus(1'b1, `REG_TXDATA, 32'h51 + 32'h11 * i, r);
			for (int i = 0; i < 6; i++) begin
				u_host_terminal_model.get(c, 8, B3, 1'b0);
				chk(c, 8'h51 + 8'h11 * i);
			end
		join
	endtask
	task automatic t_echo();
		fork
			u_host_terminal_model.send(8'h3C, 8, B3);
			u_host_terminal_model.get(c, 8, B3, 1'b0);
		join
		chk(c, 8'h3C);
		bus(1'b0, `REG_RXDATA, 32'h0, r);
		chk(r, 32'h13C);
		bus(1'b0, `REG_RXDATA, 32'h0, r);
		chk(r[8], 1'b0);
	endtask
	task automatic t_crlf(input int nb, bc, input logic [7:0] cr, lf);
		@(posedge CLOCK);
		MORSE_SPECIAL <= 1'b1;
		@(posedge CLOCK);
		MORSE_SPECIAL <= 1'b0;
		u_host_terminal_model.get(c, nb, bc, 1'b0);
		chk(c, cr);
		u_host_terminal_model.get(c, nb, bc, 1'b0);
		chk(c, lf);
	endtask
	// an all-zero char would show nine space bits if not muted
	task automatic t_ptt();
		@(posedge CLOCK);
		PTT_CLOSED <= 1'b1;
		repeat (8) @(posedge CLOCK);
		bus(1'b1, `REG_TXDATA, 32'h0, r);
		n = 0;
		repeat (12 * B3) begin
			@(posedge CLOCK);
			if (TXD_OUT !== 1'b1)
				n++;
		end
		chk(n, 0);
		PTT_CLOSED <= 1'b0;
	endtask
	// bit7 clear: an eight-bit frame would put space where the stop sits
	task automatic t_7n2();
		bus(1'b1, `REG_CTRL, 32'h1, r);
		fork
			bus(1'b1, `REG_TXDATA, 32'h2A, r);
			u_host_terminal_model.get(c, 7, B3, 1'b0);
		join
		chk(c, 8'h2A);
		bus(1'b1, `REG_CTRL, 32'h0, r);
	endtask
	// half duplex: a host frame that starts under our own is dropped
	task automatic t_half();
		cfg(8'hD3);
		repeat (2 * B3) @(posedge CLOCK);
		fork
			bus(1'b1, `REG_TXDATA, 32'h55, r);
			begin
				repeat (20) @(posedge CLOCK);
				u_host_terminal_model.send(8'hFF, 8, B3);
			end
		join
		bus(1'b0, `REG_RXDATA, 32'h0, r);
		chk(r[8], 1'b0);
	endtask
	task automatic t_inv();
		cfg(8'h1E);
		chk(TXD_OUT, 1'b0);
		fork
			bus(1'b1, `REG_TXDATA, 32'hC3, r);
			u_host_terminal_model.get(c, 8, B24, 1'b1);
		join
		chk(c, 8'hC3);
	endtask
	// echo off, so junk frames from the inverted idle stay off the line
	task automatic t_mismatch();
		cfg(8'h5C);
		wait_led(5'h00);
		chk(LED_RUN, 5'h01);
		wait_led(5'h01);
		chk(n, 8 * B24);
		chk(LED_RUN, 5'h02);
		wait_led(5'h02);
		chk(n, 8 * B24);
		bus(1'b0, `REG_STATUS, 32'h0, r);
		chk(r, 32'h15C);
	endtask
	// ------
	// run
	// ------
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// hang guard, about two and a half times the expected run
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		repeat (4) @(posedge CLOCK);
		RST_N <= 1'b1;
		repeat (10) @(posedge CLOCK);
		t_reset();
		t_fifo();
		t_echo();
		t_crlf(8, B3, `ASCII_CR, `ASCII_LF);
		t_ptt();
		t_7n2();
		t_half();
		cfg(8'h33);
		t_crlf(5, B1, `BAUDOT_CR, `BAUDOT_LF);
		t_inv();
		t_mismatch();
		finish_test();
	end
endmodule
bind host_serial_port_config host_serial_port_config_monitor u_host_serial_port_config_monitor (
	.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PTT_CLOSED(PTT_CLOSED),
	.MORSE_SPECIAL(MORSE_SPECIAL), .TXD_OUT(TXD_OUT), .LED_RUN(LED_RUN));
`default_nettype wire

// ==== dv/host_terminal_model.sv ====
// Purpose: behavioural host terminal on the serial line
// Assumes: bit time given in clock cycles
// Notes:   line idles at mark, never released
`timescale 1ns/1ps
`default_nettype none
module host_terminal_model (
	input  wire logic clk,
	input  wire logic line_in,
	output var  logic line_out
);
	initial line_out = 1'b1;
	// one frame out: start at space, lsb first, two stops at mark
	task automatic send(input logic [7:0] d, input int n, input int bc);
		line_out <= 1'b0;
		repeat (bc) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (bc) @(posedge clk);
		end
		line_out <= 1'b1;
		repeat (2 * bc) @(posedge clk);
	endtask
	// one frame in, may run beside send; bad stop reads as ff
	task automatic get(output logic [7:0] d, input int n, input int bc, input logic inv);
		int t;
		d = 8'h00;
		t = 0;
		while ((line_in ^ inv) !== 1'b0 && t < 20000) begin
			@(posedge clk);
			t++;
		end
		repeat (bc / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (bc) @(posedge clk);
			d[i] = line_in ^ inv;
		end
		repeat (bc) @(posedge clk);
		if ((line_in ^ inv) !== 1'b1)
			d = 8'hFF;
	endtask
endmodule
`default_nettype wire

// ==== inc/host_serial_port_config_defs.vh ====
// Purpose: shared constants of the host serial port (offsets, fields, resets, timing)
// Assumes: 100 MHz system clock, switch ON reads as 1
// Notes:   definitions only
`ifndef HOST_SERIAL_PORT_CONFIG_DEFS_VH
`define HOST_SERIAL_PORT_CONFIG_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_TXDATA      8'h00
`define REG_RXDATA      8'h04
`define REG_STATUS      8'h08
`define REG_CTRL        8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_SEVEN_BIT  0
`define CTRL_RESAMPLE   1
`define RX_VALID_BIT    8
`define RX_ERR_BIT      9
`define ST_MISMATCH     8
`define ST_TXBUSY       9
`define ST_FIFO_FULL    10
`define SW_TX_POL       0
`define SW_RX_POL       1
`define SW_SPEED_LO     2
`define SW_SPEED_HI     4
`define SW_BAUDOT       5
`define SW_ECHO_OFF     6
`define SW_HALF_DUPLEX  7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RESET      1'b0
`define CFG_RESET       8'h13
`define CRLF_NONE       2'd0

// ----------------------------------------
// timing: rates in hundredths of a baud
// ----------------------------------------
`define CLK_HZ_DEFAULT  100000000
`define OVERSAMPLE      64'd16
`define CAPTURE_DELAY   2'd3
`define MISMATCH_BITS   5'd20
`define LED_STEP_BITS   4'd8
`define ASCII_CB0       32'd10000
`define ASCII_CB1       32'd11000
`define ASCII_CB2       32'd15000
`define ASCII_CB3       32'd20000
`define ASCII_CB4       32'd30000
`define ASCII_CB5       32'd60000
`define ASCII_CB6       32'd120000
`define ASCII_CB7       32'd240000
`define BAUDOT_CB0      32'd4545
`define BAUDOT_CB1      32'd5000
`define BAUDOT_CB2      32'd5688
`define BAUDOT_CB3      32'd7420
`define BAUDOT_CB4      32'd10000
`define BAUDOT_CB5      32'd11000
`define BAUDOT_CB6      32'd15000
`define BAUDOT_CB7      32'd20000

// ----------------------------------------
// line codes
// ----------------------------------------
`define ASCII_CR        8'h0D
`define ASCII_LF        8'h0A
`define BAUDOT_CR       8'h08
`define BAUDOT_LF       8'h02

`endif

// ==== src/char_fifo.v ====
// Purpose: small synchronous FIFO for characters on their way to the line
// Assumes: one clock, DEPTH a power of two
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr_reg;
	reg [AW:0]      rd_ptr_reg;
	wire            push;
	wire            pop;

	// ----------------------------------------
	// flags from pointer difference
	// ----------------------------------------
	// extra pointer bit tells full from empty without a counter
	assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != DEPTH[AW:0];
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage, no reset needed
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ==== src/host_serial_port_config.v ====
// Purpose: host-side asynchronous serial port, configured from eight switches
// Assumes: AHB-Lite single word transfers, switches and line pins asynchronous
// Notes:
// Contract
// - Link runs between 45.45 and 2400 baud, same rate at both ends.
// - No parity; eight data bits one stop, or seven data bits two stops.
// - Full or half duplex operation; full duplex preferred.
// - Switch 1 ON sends normal transmit polarity, OFF inverted.
// - Switch 2 ON reads receive line normally, OFF inverted.
// - Switches 5,4,3 speed code; ASCII 100 to 2400 baud.
// - Same code in Baudot selects 45.45 to 200 baud.
// - Switch 6 code, switch 7 echo off, switch 8 half duplex.
// - Factory speed code 100 gives 300 ASCII or 100 Baudot.
// - Receive polarity mismatch runs the five status LEDs in sequence.
// - Special Morse character makes the port send CR then LF.
// - Echo enabled returns received characters while push-to-talk is open.
// - Push-to-talk closed holds the transmit output quiet.
`timescale 1ns/1ps
`default_nettype none
`include "host_serial_port_config_defs.vh"

module host_serial_port_config #(
	parameter [31:0] CLK_HZ = `CLK_HZ_DEFAULT
) (
	input  wire        CLOCK,
	input  wire        RST_N,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output reg  [31:0] HRDATA,
	output reg         HREADYOUT,
	output reg         HRESP,
	input  wire [7:0]  SWITCHES,
	input  wire        RXD_IN,
	input  wire        PTT_CLOSED,
	input  wire        MORSE_SPECIAL,
	output reg         TXD_OUT,
	output reg  [4:0]  LED_RUN
);

	localparam [63:0] CLK_CB = {32'h0, CLK_HZ} * 64'd100;
	localparam TX_IDLE = 2'b01;
	localparam TX_SEND = 2'b10;
	localparam RX_IDLE  = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_DATA  = 4'b0100;
	localparam RX_STOP  = 4'b1000;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// oversample divisor for a speed code, never below one
	function [17:0] bit_div;
		input       baudot;
		input [2:0] code;
		reg [31:0]  cb;
		reg [63:0]  q;
		begin
			case ({baudot, code})
				4'h0: cb = `ASCII_CB0;
				4'h1: cb = `ASCII_CB1;
				4'h2: cb = `ASCII_CB2;
				4'h3: cb = `ASCII_CB3;
				4'h4: cb = `ASCII_CB4;
				4'h5: cb = `ASCII_CB5;
				4'h6: cb = `ASCII_CB6;
				4'h7: cb = `ASCII_CB7;
				4'h8: cb = `BAUDOT_CB0;
				4'h9: cb = `BAUDOT_CB1;
				4'hA: cb = `BAUDOT_CB2;
				4'hB: cb = `BAUDOT_CB3;
				4'hC: cb = `BAUDOT_CB4;
				4'hD: cb = `BAUDOT_CB5;
				4'hE: cb = `BAUDOT_CB6;
				default: cb = `BAUDOT_CB7;
			endcase
			q = CLK_CB / ({32'h0, cb} * `OVERSAMPLE);
			bit_div = (q == 64'd0) ? 18'd1 : q[17:0];
		end
	endfunction

	// ----------------------------------------
	// synchronisers and configuration
	// ----------------------------------------
	reg [7:0]  sw_meta_reg, sw_reg;
	reg        rx_meta_reg, rx_sync_reg;
	reg        ptt_meta_reg, ptt_sync_reg;
	reg [7:0]  cfg_reg;
	reg [1:0]  cap_cnt_reg;
	reg        cap_done_reg;
	reg        seven_reg;
	reg [17:0] div_reg;
	reg        resample_reg;
	wire       rx_line, ptt, tx_pol, rx_pol, baudot, echo_on, half_duplex_select;
	wire [3:0] db, nbits;

	// switch, receive line and push-to-talk pins pass two flops before any logic sees them
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sw_meta_reg  <= 8'h00;
			sw_reg       <= 8'h00;
			rx_meta_reg  <= 1'b1;
			rx_sync_reg  <= 1'b1;
			ptt_meta_reg <= 1'b0;
			ptt_sync_reg <= 1'b0;
		end else begin
			sw_meta_reg  <= SWITCHES;
			sw_reg       <= sw_meta_reg;
			rx_meta_reg  <= RXD_IN;
			rx_sync_reg  <= rx_meta_reg;
			ptt_meta_reg <= PTT_CLOSED;
			ptt_sync_reg <= ptt_meta_reg;
		end
	end

	assign tx_pol   = cfg_reg[`SW_TX_POL];
	assign rx_pol   = cfg_reg[`SW_RX_POL];
	assign baudot   = cfg_reg[`SW_BAUDOT];
	assign echo_on  = ~cfg_reg[`SW_ECHO_OFF];
	assign half_duplex_select = cfg_reg[`SW_HALF_DUPLEX];
	assign rx_line  = rx_sync_reg ^ ~rx_pol;
	assign ptt      = ptt_sync_reg;
	// Baudot carries five data bits and two stops
	assign db       = baudot ? 4'd5 : (seven_reg ? 4'd7 : 4'd8);
	assign nbits    = 4'd1 + db + ((baudot | seven_reg) ? 4'd2 : 4'd1);

	// switches latched once synchronisers settle, engines held until then
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_reg      <= `CFG_RESET;
			cap_cnt_reg  <= 2'd0;
			cap_done_reg <= 1'b0;
			div_reg      <= 18'd1;
		end else if (!cap_done_reg || resample_reg) begin
			if (cap_cnt_reg == `CAPTURE_DELAY - 2'd1) begin
				cfg_reg      <= sw_reg;
				div_reg      <= bit_div(sw_reg[`SW_BAUDOT],
				                        sw_reg[`SW_SPEED_HI:`SW_SPEED_LO]);
				cap_done_reg <= 1'b1;
				cap_cnt_reg  <= 2'd0;
			end else begin
				cap_done_reg <= 1'b0;
				cap_cnt_reg  <= cap_cnt_reg + 2'd1;
			end
		end
	end

	// ----------------------------------------
	// oversample and bit ticks
	// ----------------------------------------
	reg [17:0] os_cnt_reg;
	reg [3:0]  phase_reg;
	wire       os_tick, bit_tick;
	assign os_tick  = cap_done_reg && (os_cnt_reg >= div_reg - 18'd1);
	assign bit_tick = os_tick && (phase_reg == 4'hF);

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			os_cnt_reg <= 18'd0;
			phase_reg  <= 4'h0;
		end else if (!cap_done_reg || os_tick) begin
			os_cnt_reg <= 18'd0;
			phase_reg  <= cap_done_reg ? phase_reg + 4'h1 : 4'h0;
		end else begin
			os_cnt_reg <= os_cnt_reg + 18'd1;
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	reg        wr_tx_pend_reg;
	reg        rx_valid_reg, rx_err_reg;
	reg [7:0]  rx_data_reg;
	reg        mismatch_reg;
	reg [1:0]  tx_state_reg;
	wire       fifo_in_ready, fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire       acc, acc_wr, acc_rd;
	wire [7:0] aoff;
	reg        wr_ctrl_reg;
	reg [1:0]  crlf_cnt_reg;
	reg        echo_pend_reg;
	reg        rx_done;
	reg [7:0]  rx_word;

	assign acc    = HSEL && HREADY && HTRANS[1];
	assign acc_wr = acc && HWRITE;
	assign acc_rd = acc && !HWRITE;
	assign aoff   = {HADDR[7:2], 2'b00};

	// read data registered in the address phase: zero wait reads;
	// a TXDATA write waits in its data phase until the cycle after the FIFO has room
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA         <= 32'h0;
			HREADYOUT      <= 1'b1;
			HRESP          <= 1'b0;
			wr_tx_pend_reg <= 1'b0;
			wr_ctrl_reg    <= 1'b0;
		end else begin
			HRESP       <= 1'b0;
			wr_ctrl_reg <= acc_wr && (aoff == `REG_CTRL);
			if (wr_tx_pend_reg && fifo_in_ready) begin
				wr_tx_pend_reg <= 1'b0;
				HREADYOUT      <= 1'b1;
			end else if (acc_wr && (aoff == `REG_TXDATA)) begin
				wr_tx_pend_reg <= 1'b1;
				HREADYOUT      <= 1'b0;
			end
			if (acc_rd) begin
				case (aoff)
					`REG_RXDATA: HRDATA <= {22'h0, rx_err_reg, rx_valid_reg, rx_data_reg};
					`REG_STATUS: HRDATA <= {21'h0, ~fifo_in_ready, tx_state_reg[1], mismatch_reg, cfg_reg};
					`REG_CTRL:   HRDATA <= {31'h0, seven_reg};
					default:     HRDATA <= 32'h0;
				endcase
			end
		end
	end

	// control register, written in the data phase
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			seven_reg    <= `CTRL_RESET;
			resample_reg <= 1'b0;
		end else begin
			if (wr_ctrl_reg) begin
				seven_reg <= HWDATA[`CTRL_SEVEN_BIT];
			end
			if (wr_ctrl_reg && HWDATA[`CTRL_RESAMPLE]) begin
				resample_reg <= 1'b1;
			end else if (cap_done_reg && cap_cnt_reg == 2'd0 && resample_reg && os_cnt_reg != 18'd0) begin
				resample_reg <= 1'b0;
			end else if (!cap_done_reg && cap_cnt_reg == `CAPTURE_DELAY - 2'd1) begin
				resample_reg <= 1'b0;
			end
		end
	end

	// receive holding register: a new character wins over a read clear
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rx_valid_reg <= 1'b0;
			rx_err_reg   <= 1'b0;
			rx_data_reg  <= 8'h00;
		end else if (rx_done) begin
			rx_valid_reg <= 1'b1;
			rx_err_reg   <= !rx_line;
			rx_data_reg  <= rx_word;
		end else if (acc_rd && aoff == `REG_RXDATA) begin
			rx_valid_reg <= 1'b0;
		end
	end

	char_fifo #(
		.WIDTH (8),
		.DEPTH (4),
		.AW    (2)
	) u_tx_fifo (
		.clk       (CLOCK),
		.rst_n     (RST_N),
		.in_data   (HWDATA[7:0]),
		.in_valid  (wr_tx_pend_reg),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (tx_state_reg[0] && cap_done_reg && crlf_cnt_reg == `CRLF_NONE && !echo_pend_reg)
	);

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	reg [10:0] tx_sh_reg;
	reg [3:0]  tx_left_reg, tx_os_reg;
	reg [7:0]  echo_data_reg;
	reg        tx_go;
	reg [7:0]  tx_char;
	wire [7:0] dmask;
	assign dmask = 8'hFF >> (4'd8 - db);

	// source pick: line ends first, then echo, then software
	always @* begin
		tx_go   = 1'b0;
		tx_char = 8'h00;
		if (tx_state_reg[0] && cap_done_reg) begin
			if (crlf_cnt_reg == 2'd2) begin
				tx_go   = 1'b1;
				tx_char = baudot ? `BAUDOT_CR : `ASCII_CR;
			end else if (crlf_cnt_reg == 2'd1) begin
				tx_go   = 1'b1;
				tx_char = baudot ? `BAUDOT_LF : `ASCII_LF;
			end else if (echo_pend_reg) begin
				tx_go   = 1'b1;
				tx_char = echo_data_reg;
			end else if (fifo_out_valid) begin
				tx_go   = 1'b1;
				tx_char = fifo_out_data;
			end
		end
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tx_state_reg  <= TX_IDLE;
			tx_sh_reg     <= 11'h7FF;
			tx_left_reg   <= 4'd0;
			tx_os_reg     <= 4'd0;
			crlf_cnt_reg  <= `CRLF_NONE;
			echo_pend_reg <= 1'b0;
			echo_data_reg <= 8'h00;
			TXD_OUT       <= 1'b1;
		end else begin
			// a new special character restarts the pair, winning over progress
			if (MORSE_SPECIAL) begin
				crlf_cnt_reg <= 2'd2;
			end else if (tx_go && crlf_cnt_reg != `CRLF_NONE) begin
				crlf_cnt_reg <= crlf_cnt_reg - 2'd1;
			end
			if (rx_done && echo_on && !ptt) begin
				echo_pend_reg <= 1'b1;
				echo_data_reg <= rx_word;
			end else if (tx_go && crlf_cnt_reg == `CRLF_NONE) begin
				echo_pend_reg <= 1'b0;
			end
			case (tx_state_reg)
				TX_IDLE: begin
					if (tx_go) begin
						// unused data slots filled with mark, so they act as stops
						tx_sh_reg    <= {2'b11, (tx_char & dmask) | ~dmask, 1'b0};
						tx_left_reg  <= nbits;
						tx_os_reg    <= 4'd0;
						tx_state_reg <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (os_tick) begin
						tx_os_reg <= tx_os_reg + 4'd1;
						if (tx_os_reg == 4'hF) begin
							tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
							tx_left_reg <= tx_left_reg - 4'd1;
							if (tx_left_reg == 4'd1) begin
								tx_state_reg <= TX_IDLE;
							end
						end
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
			// keeps shifting under push-to-talk, only the pin is held at mark
			TXD_OUT <= ((tx_state_reg[1] ? tx_sh_reg[0] : 1'b1) | ptt) ^ ~tx_pol;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	reg [3:0]  rx_state_reg, rx_os_reg, rx_cnt_reg;
	reg [7:0]  rx_sh_reg;
	reg [4:0]  space_bits_reg;
	reg [3:0]  led_step_reg;

	// word right-aligned when the stop bit is sampled
	always @* begin
		rx_done = 1'b0;
		rx_word = rx_sh_reg >> (4'd8 - db);
		if (rx_state_reg[3] && os_tick && rx_os_reg == 4'hF) begin
			rx_done = 1'b1;
		end
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rx_state_reg <= RX_IDLE;
			rx_os_reg    <= 4'd0;
			rx_cnt_reg   <= 4'd0;
			rx_sh_reg    <= 8'h00;
		end else if (os_tick) begin
			rx_os_reg <= rx_os_reg + 4'd1;
			case (rx_state_reg)
				RX_IDLE: begin
					// half duplex: no reception starts while our own character goes out
					if (!rx_line && !(half_duplex_select && tx_state_reg[1])) begin
						rx_state_reg <= RX_START;
						rx_os_reg    <= 4'd0;
					end
				end
				RX_START: begin
					if (rx_os_reg == 4'd7) begin
						rx_os_reg    <= 4'd0;
						rx_cnt_reg   <= 4'd0;
						rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_os_reg == 4'hF) begin
						rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
						rx_cnt_reg <= rx_cnt_reg + 4'd1;
						if (rx_cnt_reg == db - 4'd1) begin
							rx_state_reg <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_os_reg == 4'hF) begin
						rx_state_reg <= RX_IDLE;
					end
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// polarity mismatch and LED run
	// ----------------------------------------
	// a line held at space for many bit times means the idle mark is read inverted
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			space_bits_reg <= 5'd0;
			mismatch_reg   <= 1'b0;
			led_step_reg   <= 4'd0;
			LED_RUN        <= 5'h00;
		end else begin
			if (rx_line) begin
				space_bits_reg <= 5'd0;
			end else if (bit_tick && space_bits_reg != `MISMATCH_BITS) begin
				space_bits_reg <= space_bits_reg + 5'd1;
			end
			if (space_bits_reg == `MISMATCH_BITS) begin
				mismatch_reg <= 1'b1;
			end else if (rx_done && rx_line) begin
				mismatch_reg <= 1'b0;
			end
			if (!mismatch_reg) begin
				LED_RUN      <= 5'h00;
				led_step_reg <= 4'd0;
			end else if (bit_tick) begin
				// the first pattern holds a full step, like every later one
				if (LED_RUN == 5'h00) begin
					LED_RUN <= 5'h01;
				end else if (led_step_reg == `LED_STEP_BITS - 4'd1) begin
					led_step_reg <= 4'd0;
					LED_RUN      <= {LED_RUN[3:0], LED_RUN[4]};
				end else begin
					led_step_reg <= led_step_reg + 4'd1;
				end
			end
		end
	end

endmodule

`default_nettype wire
